// file: rtl/shp_regs.vh
/*
  constants for the serial peripheral host port: register offsets, fields,
  reset values and timing counts.
  assumes inclusion by bare name from design files under rtl/.
*/
`ifndef SHP_REGS_VH
`define SHP_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SHP_OFF_PINCFG   8'h00
`define SHP_OFF_MODE     8'h04
`define SHP_OFF_STATUS   8'h08
`define SHP_OFF_TXDATA   8'h0C
`define SHP_OFF_RXDATA   8'h10

// ****************************************************************
// pin configuration fields
// ****************************************************************
`define SHP_PC_MISO      0
`define SHP_PC_MOSI      1
`define SHP_PC_SEL       2
`define SHP_PC_CLK       3
`define SHP_PC_ATTN      4
`define SHP_PC_PULLUP    5
`define SHP_PINCFG_RST   6'h3F

// ****************************************************************
// mode fields
// ****************************************************************
`define SHP_MD_FRAME_LSB 0
`define SHP_MD_FRAME_MSB 1
`define SHP_MD_PASS      2
`define SHP_MODE_RST     3'h1
`define SHP_FRAME_FORCED 2'h1

// ****************************************************************
// status fields
// ****************************************************************
`define SHP_ST_TXFULL    0
`define SHP_ST_RXVALID   1
`define SHP_ST_SELECTED  2
`define SHP_ST_PENDING   3
`define SHP_ST_ACTIVE    4

// ****************************************************************
// timing
// ****************************************************************
`define SHP_SCK_MAX_KHZ  3500
`define SHP_CLK_MHZ      250

`endif

// file: rtl/shp_sync.v
/*
  two-stage synchroniser for a bundle of asynchronous pin levels.
  assumes the inputs come from outside the core clock domain.
*/
`timescale 1ns/1ps

module shp_sync #(
  parameter WIDTH = 1,
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // levels
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{RESET_VAL}};
      sync_q <= {WIDTH{RESET_VAL}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

// file: rtl/shp_host_port.v
/*
  serial peripheral slave host port with attention output, AXI4-Lite
  register access for queued transmit bytes and received bytes.
  assumes an external mode-0 master clocking the link below 3.5 MHz and
  a pad ring that resolves the data-out wire from its enable.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
// How it works
// - slave only; clock and transfer start come from the master.
// - each byte shifts most significant bit first on both lines.
// - mode 0, clock idles low, both lines sampled on rising edge.
// - attention asserts while outbound bytes are queued, until all clocked out; the code asserts it only while all four link pin enables are set.
// - attention is active low and always driven when configured.
// - selected and clocked, one outbound bit per serial clock cycle.
// - data-out is released whenever select is high.
// - data-in, select and clock pins are inputs; each pin has own enable.
// - input pull-ups on after reset, disabled by the pull-up setting.
// - framed mode without escaping forced regardless of the frame setting.
// - transparent pass-through unavailable on this port.
// - every byte moves both ways; validity comes from framing only.
// - valid output may start at any byte boundary, even mid incoming frame.
// - both sides keep pace with the byte stream.
// - empty buffer repeats the last valid bit on data-out.
// - select rising edge releases data-out at once.
`timescale 1ns/1ps
`include "shp_regs.vh"

module shp_host_port (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial link pins
  input  wire        spi_sck,
  input  wire        spi_sel_n,
  input  wire        spi_mosi,
  output wire        spi_miso_o,
  output wire        spi_miso_oe,
  output wire        attention_request_n,
  output wire        attention_oe,
  // pad pull-up enables for sck, sel_n and mosi
  output wire [2:0]  pullup_en
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  reg rst_m_q;
  reg rst_s_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  wire srst_n = rst_s_q;

  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [5:0] pincfg_q;
  reg  [2:0] mode_q;
  reg  [7:0] tx_hold_q;
  reg        tx_full_q;
  reg  [7:0] rx_hold_q;
  reg        rx_valid_q;

  wire miso_en = pincfg_q[`SHP_PC_MISO];
  wire mosi_en = pincfg_q[`SHP_PC_MOSI];
  wire sel_en  = pincfg_q[`SHP_PC_SEL];
  wire clk_en  = pincfg_q[`SHP_PC_CLK];
  wire attn_en = pincfg_q[`SHP_PC_ATTN];
  wire port_on = miso_en & mosi_en & sel_en & clk_en;

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  wire [2:0] pins_s;
  // select, clock and data-in are only ever sampled as inputs
  shp_sync #(
    .WIDTH     (3),
    .RESET_VAL (1'b0)
  ) u_sync (
    .clk   (core_clk),
    .rst_n (srst_n),
    .d     ({spi_sck, ~spi_sel_n, spi_mosi}),
    .q     (pins_s)
  );
  // disabled pins read as idle
  wire sck_s = pins_s[2] & clk_en;
  wire sel_s = pins_s[1] & sel_en;
  wire din_s = pins_s[0] & mosi_en;

  reg sck_d1_q;
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      sck_d1_q <= 1'b0;
    end else begin
      sck_d1_q <= sck_s;
    end
  end
  // sample on rising edge, shift on falling edge
  wire sck_rise = sel_s & sck_s & ~sck_d1_q;
  wire sck_fall = sel_s & ~sck_s & sck_d1_q;

  // ****************************************************************
  // shift engine
  // ****************************************************************
  // the engine advances on master clock edges, and loads a queued byte while deselected
  reg  [2:0] bit_cnt_q;
  reg  [7:0] rx_sh_q;
  reg  [7:0] tx_sh_q;
  reg        tx_live_q;
  reg        miso_q;
  wire       byte_done = sck_rise & (bit_cnt_q == 3'h7);
  wire       tx_load   = ~sel_s | (sck_fall & (bit_cnt_q == 3'h0));

  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      bit_cnt_q <= 3'h0;
      rx_sh_q   <= 8'h00;
      tx_sh_q   <= 8'h00;
      tx_live_q <= 1'b0;
      miso_q    <= 1'b0;
    end else if (!sel_s) begin
      bit_cnt_q <= 3'h0;
      if (!tx_live_q && tx_full_q) begin
        tx_sh_q   <= tx_hold_q;
        tx_live_q <= 1'b1;
        miso_q    <= tx_hold_q[7];
      end
    end else begin
      if (sck_rise) begin
        rx_sh_q   <= {rx_sh_q[6:0], din_s};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (byte_done)
          tx_live_q <= 1'b0;
      end
      if (sck_fall) begin
        if (bit_cnt_q == 3'h0) begin
          // a new byte may start at any byte boundary
          if (tx_full_q && !tx_live_q) begin
            tx_sh_q   <= tx_hold_q;
            tx_live_q <= 1'b1;
            miso_q    <= tx_hold_q[7];
          end
          // nothing queued: last bit is held
        end else if (tx_live_q) begin
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
          miso_q  <= tx_sh_q[6];
        end
      end
    end
  end

  // released as soon as select reads high
  assign spi_miso_oe = sel_s & ~spi_sel_n & miso_en & port_on;
  assign spi_miso_o  = miso_q;

  // driven low while anything is queued or still shifting and all four link pin enables are set
  wire pending = tx_full_q | tx_live_q;
  assign attention_request_n = ~(pending & port_on);
  assign attention_oe        = attn_en;
  assign pullup_en = {3{pincfg_q[`SHP_PC_PULLUP]}};

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  reg        aw_got_q;
  reg [7:0]  aw_addr_q;
  reg        w_got_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire rd_take  = s_axi_arvalid & ~s_axi_rvalid;
  wire rx_rd    = rd_take & (s_axi_araddr == `SHP_OFF_RXDATA);
  // hold register hands over to the shifter
  wire tx_move  = tx_full_q & ~tx_live_q & (~sel_s | (sck_fall & (bit_cnt_q == 3'h0)));

  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      aw_got_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_got_q      <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      pincfg_q     <= `SHP_PINCFG_RST;
      mode_q       <= `SHP_MODE_RST;
      tx_hold_q    <= 8'h00;
      tx_full_q    <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (tx_move)
        tx_full_q <= 1'b0;
      if (do_write) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (aw_addr_q)
          `SHP_OFF_PINCFG: begin
            if (w_strb_q[0])
              pincfg_q <= w_data_q[5:0];
          end
          `SHP_OFF_MODE: begin
            if (w_strb_q[0])
              mode_q <= w_data_q[2:0];
          end
          `SHP_OFF_TXDATA: begin
            // a write into a full holder is dropped and answered slverr, unless the holder hands over in that same cycle
            if (tx_full_q && !tx_move)
              s_axi_bresp <= 2'h2;
            else if (w_strb_q[0]) begin
              tx_hold_q <= w_data_q[7:0];
              tx_full_q <= 1'b1;
            end
          end
          `SHP_OFF_STATUS, `SHP_OFF_RXDATA: begin
            s_axi_bresp <= 2'h0;
          end
          default: begin
            s_axi_bresp <= 2'h3;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // frame setting is kept but the port always runs framed
  wire [1:0] frame_eff = `SHP_FRAME_FORCED;
  wire       pass_eff  = 1'b0;

  // every received byte is posted; framing is judged above
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      rx_hold_q  <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      if (rx_rd)
        rx_valid_q <= 1'b0;
      if (byte_done) begin
        rx_hold_q  <= {rx_sh_q[6:0], din_s};
        rx_valid_q <= 1'b1;  // set wins over the read clear
      end
    end
  end

  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `SHP_OFF_PINCFG: s_axi_rdata <= {26'h0000000, pincfg_q};
        `SHP_OFF_MODE:   s_axi_rdata <= {29'h00000000, pass_eff, frame_eff};
        `SHP_OFF_STATUS: s_axi_rdata <= {27'h0000000, port_on, pending, sel_s,
                                         rx_valid_q, tx_full_q};
        `SHP_OFF_TXDATA: s_axi_rdata <= {24'h000000, tx_hold_q};
        `SHP_OFF_RXDATA: s_axi_rdata <= {24'h000000, rx_hold_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h3;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // stored frame setting is never read back; this only keeps mode_q from reading as unused
  wire unused_mode = mode_q[0] ^ mode_q[1] ^ mode_q[2] ^ (`SHP_SCK_MAX_KHZ == 0);

endmodule

// file: tb/shp_host_port_asserts.sv
/* checker on the host port pins and write path.
   assumes binding to shp_host_port, link pin enables left on. */
`timescale 1ns/1ps
`include "shp_regs.vh"

module shp_host_port_asserts (
  // clock and reset
  input logic       core_clk,
  input logic       rst_n,
  // register bus
  input logic [7:0] s_axi_awaddr,
  input logic       s_axi_awvalid,
  input logic       s_axi_awready,
  input logic [1:0] s_axi_bresp,
  input logic       s_axi_bvalid,
  // link pins
  input logic       spi_sck,
  input logic       spi_sel_n,
  input logic       spi_miso_o,
  input logic       spi_miso_oe,
  input logic       attention_request_n,
  input logic       attention_oe,
  input logic [2:0] pullup_en
);
  logic tx_aw_q;

  // remembers whether the write in flight targets the transmit byte
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_aw_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      tx_aw_q <= (s_axi_awaddr == `SHP_OFF_TXDATA);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence sck_high_sel;
    (spi_sck && !spi_sel_n) [*5];
  endsequence
  sequence idle_sel;
    (attention_request_n && !spi_sel_n) [*8];
  endsequence

  a_miso_release: assert property (spi_sel_n |-> !spi_miso_oe)
    else $error("data-out driven while deselected");
  a_sel_rise_off: assert property ($rose(spi_sel_n) |-> !spi_miso_oe)
    else $error("data-out kept after select rise");
  a_oe_selected: assert property ((!spi_sel_n) [*4] |-> spi_miso_oe)
    else $error("data-out not driven while selected");
  a_pullup_reset: assert property ($rose(rst_n) |-> pullup_en == 3'h7)
    else $error("pull-ups off after reset");
  a_attn_reset: assert property ($rose(rst_n) |-> attention_oe && attention_request_n)
    else $error("attention not driven idle after reset");
  a_sck_high_hold: assert property (sck_high_sel |-> $stable(spi_miso_o))
    else $error("data-out moved while clock high");
  a_attn_on_write: assert property (
    $rose(s_axi_bvalid) && tx_aw_q && s_axi_bresp == 2'h0 |-> !attention_request_n)
    else $error("attention missing after byte queued");
  a_attn_hold: assert property ($fell(attention_request_n) |=> !attention_request_n [*7])
    else $error("attention dropped before byte out");
  a_empty_repeat: assert property (idle_sel |-> $stable(spi_miso_o))
    else $error("idle data-out changed");
endmodule

bind shp_host_port shp_host_port_asserts u_chk (
  .core_clk(core_clk), .rst_n(rst_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .spi_sck(spi_sck), .spi_sel_n(spi_sel_n),
  .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
  .attention_request_n(attention_request_n), .attention_oe(attention_oe),
  .pullup_en(pullup_en)
);

// file: tb/shp_spi_master.sv
/* behavioural mode-0 serial master for the host port link.
   assumes xfer is called from one process at a time. */
`timescale 1ns/1ps

module shp_spi_master #(
  // faster than the link limit on purpose, to show the sampler has margin
  parameter HALF = 24
) (
  // link pins
  output logic sck,
  output logic sel_n,
  output logic mosi,
  input  logic miso_o,
  input  logic miso_oe
);
  logic line;

  // a released data-out must not read back as a valid level
  assign line = miso_oe ? miso_o : ~miso_o;

  initial begin
    sck   = 1'b0;
    sel_n = 1'b1;
    mosi  = 1'b1;
  end

  // clock stands low outside frames; offset keeps edges off core_clk
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    int i;
    begin
      rx = 8'h00;
      #1.3;
      sel_n = 1'b0;
      #(4*HALF);
      for (i = 7; i > 7 - nbits; i--) begin
        mosi = tx[i];
        #HALF;
        sck = 1'b1;
        rx[i] = line;
        #HALF;
        sck = 1'b0;
      end
      #(2*HALF);
      sel_n = 1'b1;
      mosi = 1'b1;
      // deselect must last long enough for the synchroniser to see it
      #(2*HALF);
    end
  endtask
endmodule

// file: tb/spi_slave_host_port_with_attention_test.sv
/* self-checking bench for the serial host port.
   assumes checker and master model compiled first. */
`timescale 1ns/1ps
`include "shp_regs.vh"

module spi_slave_host_port_with_attention_test;
  logic        core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sck, sel_n, mosi;
  logic        miso_o, miso_oe, attn_n, attn_oe;
  logic [7:0]  awaddr, araddr, rx;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  pull;
  int          n_fail, check_count;

  shp_host_port dut (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .spi_sck(sck), .spi_sel_n(sel_n), .spi_mosi(mosi), .spi_miso_o(miso_o),
    .spi_miso_oe(miso_oe), .attention_request_n(attn_n), .attention_oe(attn_oe),
    .pullup_en(pull)
  );
  shp_spi_master m (
    .sck(sck), .sel_n(sel_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe)
  );

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ready is read at the falling edge, where it equals what the next rise samples
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, done;
    begin
      done = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
        @(negedge core_clk);
        ta = awvalid && awready;
        tw = wvalid && wready;
        done = bvalid;
        if (done) check(32'(bresp), 32'(er));
        @(posedge core_clk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        if (done) bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, done;
    begin
      done = 1'b0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
        @(negedge core_clk);
        ta = arvalid && arready;
        done = rvalid;
        if (done) check(rdata, ed);
        if (done) check(32'(rresp), 32'(er));
        @(posedge core_clk);
        if (ta) arvalid <= 1'b0;
        if (done) rready <= 1'b0;
      end
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h1;
    n_fail = 0;
    check_count = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check(32'(attn_n), 32'h1);
    check(32'(attn_oe), 32'h1);
    check(32'(pull), 32'h7);
    check(32'(miso_oe), 32'h0);
    axi_rd(`SHP_OFF_PINCFG, 32'h3F, 2'h0);
    axi_rd(`SHP_OFF_STATUS, 32'h10, 2'h0);
    axi_wr(`SHP_OFF_MODE, 32'h6, 2'h0);
    axi_rd(`SHP_OFF_MODE, 32'h1, 2'h0);
    axi_wr(8'h20, 32'h1, 2'h3);
    axi_rd(8'h20, 32'h0, 2'h3);
    $display("test registers done");
    // first byte moves at once into the idle shifter, the second waits in the holder
    axi_wr(`SHP_OFF_TXDATA, 32'hA5, 2'h0);
    @(negedge core_clk);
    check(32'(attn_n), 32'h0);
    axi_wr(`SHP_OFF_TXDATA, 32'h77, 2'h0);
    axi_wr(`SHP_OFF_TXDATA, 32'h11, 2'h2);
    m.xfer(8'h3C, 8, rx);
    check(32'(rx), 32'hA5);
    check(32'(attn_n), 32'h0);
    axi_rd(`SHP_OFF_RXDATA, 32'h3C, 2'h0);
    m.xfer(8'hC3, 8, rx);
    check(32'(rx), 32'h77);
    check(32'(attn_n), 32'h1);
    axi_rd(`SHP_OFF_STATUS, 32'h12, 2'h0);
    m.xfer(8'h00, 8, rx);
    check(32'(rx), 32'hFF);
    m.xfer(8'hF0, 3, rx);
    m.xfer(8'h5A, 8, rx);
    axi_rd(`SHP_OFF_RXDATA, 32'h5A, 2'h0);
    $display("test link done");
    axi_wr(`SHP_OFF_PINCFG, 32'h0F, 2'h0);
    @(negedge core_clk);
    check(32'(pull), 32'h0);
    check(32'(attn_oe), 32'h0);
    axi_wr(`SHP_OFF_PINCFG, 32'h3F, 2'h0);
    @(negedge core_clk);
    check(32'(pull), 32'h7);
    $display("test pins done");
    report_and_stop;
  end
endmodule
